// [design/fmsp_tone.sv]
// constants package for the modem host serial port, and the fsk tone generator
// assumes one 125 MHz clock with a synchronous active-low reset
`default_nettype none

package fmsp_pkg;
  // clock and timing
  localparam longint CLK_HZ = 125000000;
  localparam int POR_WAIT_MS = 30;
  localparam int POR_WAIT_CYCLES = int'((longint'(POR_WAIT_MS) * CLK_HZ + 999) / 1000);
  // tone frequencies and phase accumulator
  localparam int ACC_W = 32;
  localparam longint TONE_MARK_HZ = 1200;
  localparam longint TONE_SPACE_HZ = 2200;
  localparam logic [31:0] INC_MARK = 32'((TONE_MARK_HZ << ACC_W) / CLK_HZ);
  localparam logic [31:0] INC_SPACE = 32'((TONE_SPACE_HZ << ACC_W) / CLK_HZ);
  // line levels
  localparam logic LINE_MARK = 1'h1;
  // synchroniser bit positions and reset pattern
  localparam int SY_SUPPLY = 0;
  localparam int SY_EXTCLK = 1;
  localparam int SY_CARRIER = 2;
  localparam int SY_TXD = 3;
  localparam int SY_RTS_N = 4;
  localparam int SY_DEMOD = 5;
  localparam int SY_W = 6;
  localparam logic [5:0] SY_RESET = 6'h38;
  // supervisor states
  typedef enum logic [2:0] {
    FMSP_HOLD = 3'h1,
    FMSP_WAIT = 3'h2,
    FMSP_RUN = 3'h4
  } fmsp_sup_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module fmsp_tone (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // control
  input wire logic enable_in,
  input wire logic mark_in,
  // tone
  output logic tone_out
);
  logic [fmsp_pkg::ACC_W-1:0] acc;
  logic [fmsp_pkg::ACC_W-1:0] next_acc;
  logic next_tone;

  // phase accumulator, restarted at zero phase whenever idle
  always_comb begin
    next_acc = '0;
    next_tone = 1'h0;
    if (enable_in) begin
      next_acc = acc + (mark_in ? fmsp_pkg::INC_MARK : fmsp_pkg::INC_SPACE); // R17
      next_tone = acc[fmsp_pkg::ACC_W-1];
    end
  end

  // registers
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      acc <= '0;
      tone_out <= 1'h0;
    end else begin
      acc <= next_acc;
      tone_out <= next_tone;
    end
  end

  property p_tone_step;
    @(posedge mclk_in) disable iff (!nrst_in)
    enable_in |=> (acc == $past(acc) + ($past(mark_in) ? fmsp_pkg::INC_MARK
                                                        : fmsp_pkg::INC_SPACE));
  endproperty
  a_tone_step: assert property (p_tone_step) else $error("tone step wrong"); // R17

  property p_tone_idle;
    @(posedge mclk_in) disable iff (!nrst_in)
    !enable_in |=> (acc == '0) && !tone_out;
  endproperty
  a_tone_idle: assert property (p_tone_idle) else $error("tone not idle"); // R17
endmodule

`default_nettype wire

// [design/fmsp_top.sv]
// modem host serial port: supervisor, clock select, carrier detect, serial path
// assumes pins pass through the synchroniser here; analog front end is outside
// Operation
// R01: reset held low while supply is below threshold, then 30 ms wait.
// R02: reset output only pulls low; external pull-up gives high level.
// R03: modem clock is one of four permitted frequencies.
// R04: external modem clock stays within one percent of nominal.
// R05: supplied clock duty cycle stays between 35 and 65 percent.
// R06: external clock selected shuts the internal oscillator down.
// R07: carrier output high with signal above threshold, low otherwise; the code also holds it low unless the receive path is enabled.
// R08: characters at 1200 baud, eleven bit times each.
// R09: request-to-send high keeps transmitter off, no modulated output.
// R10: host drives request-to-send low before the first data bit.
// R11: no buffering; bits modulated and passed straight through.
// R12: receive transitions may shift up to 12 percent of a bit.
// R13: receiver samples mid-bit, tolerating 45 percent boundary shift.
// R14: oversampling receiver may use a three-sample majority vote.
// R15: receiver tolerates 35 percent shift even with perfect time base.
// R16: half duplex: receive off while sending, transmit off while receiving.
// R17: mark sent as 1200 Hz tone, space as 2200 Hz.
`default_nettype none

module fmsp_top #(
  parameter int POR_CYCLES = fmsp_pkg::POR_WAIT_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // analog comparators and straps
  input wire logic supply_sense_input_in,
  input wire logic ext_clk_sel_in,
  input wire logic carrier_level_in,
  input wire logic demod_bit_in,
  // host serial pins
  input wire logic txd_in,
  input wire logic send_request_n_in,
  // supervisor open-drain reset
  output logic supervisor_reset_n_out,
  output logic supervisor_reset_n_oe_n_out,
  // status and path outputs
  output logic osc_enable_out,
  output logic carrier_present_out,
  output logic rxd_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic tone_out
);
  localparam int CNT_W = $clog2(POR_CYCLES + 1);

  logic [fmsp_pkg::SY_W-1:0] sy1;
  logic [fmsp_pkg::SY_W-1:0] sy2;
  fmsp_pkg::fmsp_sup_t state;
  fmsp_pkg::fmsp_sup_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_oe_n;
  logic next_osc;
  logic next_cd;
  logic next_rxd;
  logic next_tx;
  logic next_rx;
  logic supply_ok;
  logic rts_n;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on every pin input
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sy1 <= fmsp_pkg::SY_RESET;
      sy2 <= fmsp_pkg::SY_RESET;
    end else begin
      sy1 <= {demod_bit_in, send_request_n_in, txd_in,
              carrier_level_in, ext_clk_sel_in, supply_sense_input_in};
      sy2 <= sy1;
    end
  end

  assign supply_ok = sy2[fmsp_pkg::SY_SUPPLY];
  assign rts_n = sy2[fmsp_pkg::SY_RTS_N];
  assign running = (state == fmsp_pkg::FMSP_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // power supervisor
  always_comb begin
    next_state = state;
    next_cnt = '0;
    unique case (state)
      fmsp_pkg::FMSP_HOLD: begin
        if (supply_ok) begin
          next_state = fmsp_pkg::FMSP_WAIT;
        end
      end
      fmsp_pkg::FMSP_WAIT: begin
        next_cnt = cnt + CNT_W'(1);
        if (!supply_ok) begin
          next_state = fmsp_pkg::FMSP_HOLD; // R01
          next_cnt = '0;
        end else if (cnt >= CNT_W'(POR_CYCLES - 1)) begin
          next_state = fmsp_pkg::FMSP_RUN; // R01
          next_cnt = '0;
        end
      end
      fmsp_pkg::FMSP_RUN: begin
        if (!supply_ok) begin
          next_state = fmsp_pkg::FMSP_HOLD; // R01
        end
      end
      default: begin
        next_state = fmsp_pkg::FMSP_HOLD;
      end
    endcase
    // drive the open-drain pin low unless released
    next_oe_n = (next_state == fmsp_pkg::FMSP_RUN); // R02
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state <= fmsp_pkg::FMSP_HOLD;
      cnt <= '0;
      supervisor_reset_n_oe_n_out <= 1'h0;
      supervisor_reset_n_out <= 1'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      supervisor_reset_n_oe_n_out <= next_oe_n;
      supervisor_reset_n_out <= 1'h0; // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-duplex path control, carrier detect and clock source
  always_comb begin
    next_osc = !sy2[fmsp_pkg::SY_EXTCLK]; // R06
    next_tx = running && !rts_n; // R09 R16
    next_rx = running && rts_n; // R16
    next_cd = next_rx && sy2[fmsp_pkg::SY_CARRIER]; // R07
    // straight pass-through, no framing or storage
    next_rxd = next_rx ? sy2[fmsp_pkg::SY_DEMOD] : fmsp_pkg::LINE_MARK; // R08 R11 R12
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      osc_enable_out <= 1'h1;
      tx_enable_out <= 1'h0;
      rx_enable_out <= 1'h0;
      carrier_present_out <= 1'h0;
      rxd_out <= fmsp_pkg::LINE_MARK;
    end else begin
      osc_enable_out <= next_osc;
      tx_enable_out <= next_tx;
      rx_enable_out <= next_rx;
      carrier_present_out <= next_cd;
      rxd_out <= next_rxd;
    end
  end

  // modulator follows the host line bit by bit
  fmsp_tone u_tone (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .enable_in(tx_enable_out),
    .mark_in(sy2[fmsp_pkg::SY_TXD]),
    .tone_out(tone_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper: run length of supply-above-threshold, saturating
  logic [CNT_W:0] hi_run;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || !supply_ok) begin
      hi_run <= '0;
    end else if (hi_run <= (CNT_W + 1)'(POR_CYCLES)) begin
      hi_run <= hi_run + (CNT_W + 1)'(1);
    end
  end

  property p_por_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
    !supply_ok |=> !supervisor_reset_n_oe_n_out;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset not held"); // R01

  property p_por_wait;
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(supervisor_reset_n_oe_n_out) |-> $past(hi_run) >= (CNT_W + 1)'(POR_CYCLES);
  endproperty
  a_por_wait: assert property (p_por_wait) else $error("reset released early"); // R01

  property p_pull_low;
    @(posedge mclk_in) disable iff (!nrst_in)
    !supervisor_reset_n_oe_n_out |-> !supervisor_reset_n_out;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("pin driven high"); // R02

  property p_osc_off;
    @(posedge mclk_in) disable iff (!nrst_in)
    sy2[fmsp_pkg::SY_EXTCLK] |=> !osc_enable_out;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator left on"); // R06

  property p_cd_high;
    @(posedge mclk_in) disable iff (!nrst_in)
    running && rts_n && sy2[fmsp_pkg::SY_CARRIER] |=> carrier_present_out;
  endproperty
  a_cd_high: assert property (p_cd_high) else $error("carrier missed"); // R07

  property p_cd_low;
    @(posedge mclk_in) disable iff (!nrst_in)
    !sy2[fmsp_pkg::SY_CARRIER] |=> !carrier_present_out;
  endproperty
  a_cd_low: assert property (p_cd_low) else $error("carrier false"); // R07

  property p_rts_off;
    @(posedge mclk_in) disable iff (!nrst_in)
    rts_n |=> !tx_enable_out ##1 !tone_out;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("transmitting without request"); // R09

  property p_pass;
    @(posedge mclk_in) disable iff (!nrst_in)
    running && rts_n |=> rxd_out == $past(sy2[fmsp_pkg::SY_DEMOD]);
  endproperty
  a_pass: assert property (p_pass) else $error("receive bit not passed"); // R11

  property p_latency;
    @(posedge mclk_in) disable iff (!nrst_in)
    rx_enable_out && next_rx && $changed(sy2[fmsp_pkg::SY_DEMOD]) |=> $changed(rxd_out);
  endproperty
  a_latency: assert property (p_latency) else $error("receive edge delayed"); // R12

  property p_hdx;
    @(posedge mclk_in) disable iff (!nrst_in)
    tx_enable_out |-> !rx_enable_out && rxd_out && !carrier_present_out;
  endproperty
  a_hdx: assert property (p_hdx) else $error("both directions on"); // R16

  c_release: cover property (@(posedge mclk_in) disable iff (!nrst_in)
    $rose(supervisor_reset_n_oe_n_out));
  c_transmit: cover property (@(posedge mclk_in) disable iff (!nrst_in)
    tx_enable_out ##1 tone_out);
  c_receive: cover property (@(posedge mclk_in) disable iff (!nrst_in)
    carrier_present_out && $fell(rxd_out));
endmodule

`default_nettype wire

// [verif/fmsp_host.sv]
// host-side model: request line, transmit line, mid-bit voting receiver
// assumes the bench clock and a shortened bit time given in cycles
`default_nettype none

module fmsp_host #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk_in,
  // host serial pins
  input wire logic rxd_in,
  output logic txd_out,
  output logic send_request_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: mark level, no request
  initial begin
    txd_out = 1'h1;
    send_request_n_out = 1'h1;
  end

  // request and transmit level, set by the caller at a falling edge, except the first call after recv, made at a rising edge
  task automatic drive(input logic req_n, input logic bit_v);
    send_request_n_out = req_n;
    txd_out = bit_v;
  endtask

  // start edge, then three samples round each bit centre
  task automatic recv(output logic [10:0] frm);
    int v;
    @(negedge rxd_in);
    repeat (BIT / 2 - 1) @(posedge clk_in);
    for (int i = 0; i < 11; i++) begin
      v = 0;
      for (int k = 0; k < 3; k++) begin
        #1 v += int'(rxd_in);
        if (k < 2) @(posedge clk_in);
      end
      frm[i] = (v >= 2);
      repeat (BIT - 2) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// [verif/fmsp_top_test.sv]
// bench for the modem host serial port: supervisor, clock select, serial path
// assumes fmsp_host on the host pins and a shortened supervisor wait
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module fmsp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  localparam int BIT = 16;
  int bad_count = 0;
  int num_checks = 0;
  logic mclk_in = 1'h0;
  logic nrst_in = 1'h0;
  logic supply = 1'h0;
  logic ext_sel = 1'h0;
  logic carrier = 1'h0;
  logic demod = 1'h1;
  logic txd, rts_n, rst_d, rst_oe_n, osc_en, cd, rxd, tx_en, rx_en, tone;

  // 50 percent duty clock at 125 MHz
  always #4 mclk_in = ~mclk_in;

  fmsp_top #(.POR_CYCLES(POR)) DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .supply_sense_input_in(supply), .ext_clk_sel_in(ext_sel),
    .carrier_level_in(carrier), .demod_bit_in(demod), .txd_in(txd),
    .send_request_n_in(rts_n), .supervisor_reset_n_out(rst_d),
    .supervisor_reset_n_oe_n_out(rst_oe_n), .osc_enable_out(osc_en),
    .carrier_present_out(cd), .rxd_out(rxd), .tx_enable_out(tx_en),
    .rx_enable_out(rx_en), .tone_out(tone));

  fmsp_host #(.BIT(BIT)) host (.clk_in(mclk_in), .rxd_in(rxd), .txd_out(txd),
    .send_request_n_out(rts_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  // falling edges until a watched output shows a level, bounded; sel 0 reset pin, 1 tone
  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    while (((sel == 0) ? rst_oe_n : tone) !== lvl && n < 60000) begin
      cyc(1);
      n++;
    end
  endtask

  // near a half tone period, allowing for pipeline and rounding
  function automatic logic near_half(input int m, input longint f);
    int h;
    h = int'(fmsp_pkg::CLK_HZ / (2 * f));
    return (m > h - 8) && (m < h + 8);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_supervisor;
    int n;
    cyc(POR + 8);
    `CHK(rst_oe_n, 1'h0)
    supply = 1'h1;
    cyc(POR / 2);
    supply = 1'h0;
    cyc(1);
    supply = 1'h1;
    wait_for(0, 1'h1, n);
    `CHK(n, POR + 3)
    `CHK(rst_d, 1'h0)
    supply = 1'h0;
    wait_for(0, 1'h0, n);
    `CHK(n, 3)
    supply = 1'h1;
    wait_for(0, 1'h1, n);
    `CHK(n, POR + 3)
  endtask

  task automatic t_clock_select;
    ext_sel = 1'h1;
    cyc(2);
    `CHK(osc_en, 1'h1)
    cyc(1);
    `CHK(osc_en, 1'h0)
    ext_sel = 1'h0;
    cyc(3);
    `CHK(osc_en, 1'h1)
  endtask

  task automatic t_receive;
    logic [10:0] got;
    logic [10:0] frm;
    frm = {1'h1, ^8'hA5, 8'hA5, 1'h0};
    carrier = 1'h1;
    cyc(3);
    `CHK({cd, rx_en, tx_en}, 3'h6)
    carrier = 1'h0;
    cyc(3);
    `CHK(cd, 1'h0)
    carrier = 1'h1;
    fork
      host.recv(got);
      for (int i = 0; i < 11; i++) begin
        demod = frm[i];
        cyc(BIT);
      end
    join
    `CHK(got, frm)
  endtask

  task automatic t_transmit;
    int n;
    host.drive(1'h1, 1'h0);
    cyc(20);
    `CHK({tone, tx_en}, 2'h0)
    host.drive(1'h0, 1'h1);
    cyc(3);
    `CHK({tx_en, rx_en, rxd, cd}, 4'hA)
    demod = 1'h0;
    cyc(3);
    `CHK(rxd, 1'h1)
    demod = 1'h1;
    wait_for(1, 1'h1, n);
    `CHK(near_half(n + 6, 1200), 1'h1)
    host.drive(1'h1, 1'h1);
    cyc(3);
    `CHK(tx_en, 1'h0)
    // tone register lags the enable by one edge
    cyc(1);
    `CHK(tone, 1'h0)
    // request first, space bit one cycle later
    host.drive(1'h0, 1'h1);
    cyc(1);
    host.drive(1'h0, 1'h0);
    wait_for(1, 1'h1, n);
    `CHK(near_half(n, 2200), 1'h1)
    host.drive(1'h1, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(6);
    `CHK({rst_oe_n, rst_d, osc_en, cd, rxd, tx_en, rx_en, tone}, 8'h28)
    nrst_in = 1'h1;
    t_supervisor();
    t_clock_select();
    t_receive();
    t_transmit();
    tally_and_finish();
  end

  // watchdog at about 95000 cycles, above the expected run of about 81000
  initial begin
    #760000;
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
